// File: pup_defs.vh
/*
 * Constants for the pileup inspection and peak sampling block: register
 * offsets, reset values, timing figures and bus answers.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef PUP_DEFS_VH
`define PUP_DEFS_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define PUP_CLK_NS 50
`define PUP_MAXW_NS 400
`define PUP_MAXW_CYC ((`PUP_MAXW_NS + `PUP_CLK_NS - 1) / `PUP_CLK_NS)
`define PUP_FASTPK_NS 100
`define PUP_FASTPK_CYC ((`PUP_FASTPK_NS + `PUP_CLK_NS - 1) / `PUP_CLK_NS)

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PUP_OFS_CTRL 8'h00
`define PUP_OFS_FASTPEAK 8'h04
`define PUP_OFS_MAX_OVER_THRESHOLD_WIDTH 8'h08
`define PUP_OFS_FASTGAP 8'h0c
`define PUP_OFS_PEAKTIME 8'h10
`define PUP_OFS_GAPTIME 8'h14
`define PUP_OFS_INTOFS 8'h18
`define PUP_OFS_SAMPOFS 8'h1c
`define PUP_OFS_MIN_PEAK_INTERVAL 8'h20
`define PUP_OFS_ACCEPTS 8'h24
`define PUP_OFS_FASTREJ 8'h28
`define PUP_OFS_SLOWREJ 8'h2c
`define PUP_OFS_ENERGY 8'h30

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PUP_CTRL_EN 0
`define PUP_CTRL_DEC_LO 4
`define PUP_CTRL_DEC_HI 6
`define PUP_RST_CTRL 32'h00000001
`define PUP_RST_PEAKTIME 16'h0010
`define PUP_GAP_MIN 7'h03
`define PUP_GAP_MAX 7'h40
`define PUP_RST_OFS 16'h0000
`define PUP_RST_SAMPOFS 16'h0001

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define PUP_RESP_OKAY 2'b00
`define PUP_RESP_SLVERR 2'b10

`endif

// File: pup_pileup_inspector.v
/*
 * Pileup inspection and energy peak sampling, with an AXI4-Lite register slave.
 * Assumes the fast filter threshold level, the event trigger pulse and the
 * energy filter output are all synchronous to mclk.
 */
// Summary of operation
// RULE1: Fast trigger over threshold beyond programmed maximum width rejects the event as fast pileup.
// RULE2: Maximum over-threshold width resets to 400 ns.
// RULE3: Software keeps maximum width above twice fast peaking plus preamp settling.
// RULE4: An event arriving before the peak interval elapses causes slow pileup rejection.
// RULE5: Peak interval equals peaking time plus gap time plus interval offset.
// RULE6: Software normally leaves the peak interval offset at zero.
// RULE7: Fast peaking time resets to 100 ns and stays writable.
// RULE8: Software keeps the fast gap time at zero.
// RULE9: Software may shorten fast peaking, then rechecks threshold and maximum width.
// RULE10: Energy is sampled at peaking plus gap minus the peak sample offset.
// RULE11: Energy gap time is held between 3 and 64 decimated intervals.
// RULE12: Only events passing both checks deliver an energy value downstream.
`timescale 1ns/1ns

`include "pup_defs.vh"

module pup_pileup_inspector #(
    parameter EW = 16,
    parameter CW = 16
) (
    input wire mclk,
    input wire resetn,
    input wire fastAboveThr,
    input wire eventTrig,
    input wire [EW-1:0] energyIn,
    output reg [EW-1:0] energyOut,
    output reg energyValid,
    output reg fastPileup,
    output reg slowPileup,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [6:0] clampGap;
        input [31:0] v;
        begin
            if (v < {25'h0000000, `PUP_GAP_MIN}) begin
                clampGap = `PUP_GAP_MIN;
            end else if (v > {25'h0000000, `PUP_GAP_MAX}) begin
                clampGap = `PUP_GAP_MAX;
            end else begin
                clampGap = v[6:0];
            end
        end
    endfunction

    function isMapped;
        input [7:0] a;
        begin
            isMapped = (a[1:0] == 2'b00) && (a <= `PUP_OFS_ENERGY);
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [31:0] ctrl_reg;
    reg [CW-1:0] fastPeak_reg;
    reg [CW-1:0] max_over_threshold_width_reg;
    reg [CW-1:0] fastGap_reg;
    reg [CW-1:0] peakTime_reg;
    reg [6:0] gapTime_reg;
    reg [CW-1:0] intOfs_reg;
    reg [CW-1:0] sampOfs_reg;
    reg [31:0] accepts_reg;
    reg [31:0] fastRej_reg;
    reg [31:0] slowRej_reg;

    reg [7:0] div_reg;
    reg [CW-1:0] interval_reg;
    reg [CW-1:0] overCnt_reg;
    reg pending_reg;
    reg piled_reg;
    reg [EW-1:0] sample_reg;

    wire enable = ctrl_reg[`PUP_CTRL_EN];
    wire [2:0] decim = ctrl_reg[`PUP_CTRL_DEC_HI:`PUP_CTRL_DEC_LO];
    wire [7:0] decMask = (8'h01 << decim) - 8'h01;
    wire tick = ((div_reg & decMask) == decMask);
    localparam [31:0] MAXW_RST = `PUP_MAXW_CYC;
    localparam [31:0] FASTPK_RST = `PUP_FASTPK_CYC;

    // RULE5: peak interval sum
    wire [CW-1:0] min_peak_interval = peakTime_reg + {{(CW-7){1'b0}}, gapTime_reg} + intOfs_reg;
    // RULE10: sample point backward
    wire [CW-1:0] sampleAt = peakTime_reg + {{(CW-7){1'b0}}, gapTime_reg} - sampOfs_reg;

    // RULE1: width over threshold exceeded
    wire fastHit = enable && fastAboveThr && (overCnt_reg == max_over_threshold_width_reg);
    // RULE4: early follower
    wire slowHit = enable && eventTrig && pending_reg && (interval_reg < min_peak_interval);

    // ----------------------------------------
    // Event processing
    // ----------------------------------------
    always @(posedge mclk) begin
        if (!resetn) begin
            div_reg <= 8'h00;
            interval_reg <= {CW{1'b0}};
            overCnt_reg <= {CW{1'b0}};
            pending_reg <= 1'b0;
            piled_reg <= 1'b0;
            sample_reg <= {EW{1'b0}};
            energyOut <= {EW{1'b0}};
            energyValid <= 1'b0;
            fastPileup <= 1'b0;
            slowPileup <= 1'b0;
            accepts_reg <= 32'h00000000;
            fastRej_reg <= 32'h00000000;
            slowRej_reg <= 32'h00000000;
        end else begin
            div_reg <= div_reg + 8'h01;
            energyValid <= 1'b0;
            fastPileup <= fastHit;
            slowPileup <= slowHit;
            if (fastAboveThr && overCnt_reg != {CW{1'b1}}) begin
                overCnt_reg <= overCnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end else if (!fastAboveThr) begin
                overCnt_reg <= {CW{1'b0}};
            end
            if (tick && interval_reg != {CW{1'b1}}) begin
                interval_reg <= interval_reg + {{(CW-1){1'b0}}, 1'b1};
            end
            if (pending_reg && tick && interval_reg == sampleAt) begin
                sample_reg <= energyIn;
            end
            // RULE12: deliver only clean events
            if (pending_reg && tick && interval_reg == min_peak_interval) begin
                pending_reg <= 1'b0;
                if (!piled_reg) begin
                    energyOut <= sample_reg;
                    energyValid <= 1'b1;
                    accepts_reg <= accepts_reg + 32'h00000001;
                end
            end
            // A new event restarts the interval; a piled follower is itself contaminated.
            if (enable && eventTrig) begin
                // The event edge counts as a tick, so the count shows ticks elapsed.
                interval_reg <= {{(CW-1){1'b0}}, 1'b1};
                pending_reg <= 1'b1;
                piled_reg <= slowHit;
            end
            if (slowHit) begin
                slowRej_reg <= slowRej_reg + 32'h00000001;
            end
            if (fastHit) begin
                piled_reg <= 1'b1;
                fastRej_reg <= fastRej_reg + 32'h00000001;
            end
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;

    always @(posedge mclk) begin
        if (!resetn) begin
            ctrl_reg <= `PUP_RST_CTRL;
            // RULE7: fast peaking default
            fastPeak_reg <= FASTPK_RST[CW-1:0];
            // RULE2: maximum width default
            max_over_threshold_width_reg <= MAXW_RST[CW-1:0];
            fastGap_reg <= {CW{1'b0}};
            peakTime_reg <= `PUP_RST_PEAKTIME;
            gapTime_reg <= `PUP_GAP_MIN;
            intOfs_reg <= `PUP_RST_OFS;
            sampOfs_reg <= `PUP_RST_SAMPOFS;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PUP_RESP_OKAY;
        end else begin
            s_axi_awready <= wrGo;
            s_axi_wready <= wrGo;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // The response waits for the address and data handshake, which completes while awready is high.
            if (s_axi_awready) begin
                s_axi_bvalid <= 1'b1;
            end
            if (wrGo) begin
                s_axi_bresp <= isMapped(s_axi_awaddr) ? `PUP_RESP_OKAY : `PUP_RESP_SLVERR;
                // Strobes are honoured per register as a whole; any nonzero strobe writes the whole register, an all-zero strobe drops the write.
                if (s_axi_wstrb != 4'h0) begin
                    if (s_axi_awaddr == `PUP_OFS_CTRL) begin
                        ctrl_reg <= s_axi_wdata;
                    end else if (s_axi_awaddr == `PUP_OFS_FASTPEAK) begin
                        fastPeak_reg <= s_axi_wdata[CW-1:0];
                    end else if (s_axi_awaddr == `PUP_OFS_MAX_OVER_THRESHOLD_WIDTH) begin
                        max_over_threshold_width_reg <= s_axi_wdata[CW-1:0];
                    end else if (s_axi_awaddr == `PUP_OFS_FASTGAP) begin
                        fastGap_reg <= s_axi_wdata[CW-1:0];
                    end else if (s_axi_awaddr == `PUP_OFS_PEAKTIME) begin
                        peakTime_reg <= s_axi_wdata[CW-1:0];
                    end else if (s_axi_awaddr == `PUP_OFS_GAPTIME) begin
                        // RULE11: gap clamped on write
                        gapTime_reg <= clampGap(s_axi_wdata);
                    end else if (s_axi_awaddr == `PUP_OFS_INTOFS) begin
                        intOfs_reg <= s_axi_wdata[CW-1:0];
                    end else if (s_axi_awaddr == `PUP_OFS_SAMPOFS) begin
                        sampOfs_reg <= s_axi_wdata[CW-1:0];
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    reg [31:0] rdMux;

    always @* begin
        rdMux = 32'h00000000;
        if (s_axi_araddr == `PUP_OFS_CTRL) begin
            rdMux = ctrl_reg;
        end else if (s_axi_araddr == `PUP_OFS_FASTPEAK) begin
            rdMux = {{(32-CW){1'b0}}, fastPeak_reg};
        end else if (s_axi_araddr == `PUP_OFS_MAX_OVER_THRESHOLD_WIDTH) begin
            rdMux = {{(32-CW){1'b0}}, max_over_threshold_width_reg};
        end else if (s_axi_araddr == `PUP_OFS_FASTGAP) begin
            rdMux = {{(32-CW){1'b0}}, fastGap_reg};
        end else if (s_axi_araddr == `PUP_OFS_PEAKTIME) begin
            rdMux = {{(32-CW){1'b0}}, peakTime_reg};
        end else if (s_axi_araddr == `PUP_OFS_GAPTIME) begin
            rdMux = {25'h0000000, gapTime_reg};
        end else if (s_axi_araddr == `PUP_OFS_INTOFS) begin
            rdMux = {{(32-CW){1'b0}}, intOfs_reg};
        end else if (s_axi_araddr == `PUP_OFS_SAMPOFS) begin
            rdMux = {{(32-CW){1'b0}}, sampOfs_reg};
        end else if (s_axi_araddr == `PUP_OFS_MIN_PEAK_INTERVAL) begin
            rdMux = {{(32-CW){1'b0}}, min_peak_interval};
        end else if (s_axi_araddr == `PUP_OFS_ACCEPTS) begin
            rdMux = accepts_reg;
        end else if (s_axi_araddr == `PUP_OFS_FASTREJ) begin
            rdMux = fastRej_reg;
        end else if (s_axi_araddr == `PUP_OFS_SLOWREJ) begin
            rdMux = slowRej_reg;
        end else if (s_axi_araddr == `PUP_OFS_ENERGY) begin
            rdMux = {{(32-EW){1'b0}}, energyOut};
        end
    end

    wire rdGo = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

    always @(posedge mclk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PUP_RESP_OKAY;
        end else begin
            s_axi_arready <= rdGo;
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
            end
            if (rdGo) begin
                s_axi_rdata <= rdMux;
                s_axi_rresp <= isMapped(s_axi_araddr) ? `PUP_RESP_OKAY : `PUP_RESP_SLVERR;
            end
        end
    end

endmodule

// File: pup_pileup_inspector_chk.sv
/* Checker for the pileup inspector's event outputs and bus handshakes.
   Assumes it is bound into pup_pileup_inspector and sees its ports. */
`timescale 1ns/1ns
module pup_pileup_inspector_chk #(
    parameter EW = 16
) (
    input wire mclk,
    input wire resetn,
    input wire fastAboveThr,
    input wire eventTrig,
    input wire [EW-1:0] energyOut,
    input wire energyValid,
    input wire fastPileup,
    input wire slowPileup,
    input wire [7:0] s_axi_awaddr,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_arready,
    input wire s_axi_bvalid,
    input wire s_axi_rvalid
);
// ----------------------------------------
// Helper logic
// ----------------------------------------
// The run length holds after the level drops, since the pileup pulse lags the run.
reg [15:0] runLen_reg;
reg prevHi_reg;
reg [31:0] maxW_reg;
always @(posedge mclk) begin
    if (!resetn) begin
        runLen_reg <= 16'h0000;
        prevHi_reg <= 1'b0;
        maxW_reg <= 32'h00000008;
    end else begin
        prevHi_reg <= fastAboveThr;
        if (fastAboveThr)
            runLen_reg <= prevHi_reg ? runLen_reg + 16'h0001 : 16'h0001;
        if (s_axi_awready && s_axi_wready && (|s_axi_wstrb) && s_axi_awaddr == 8'h08)
            maxW_reg <= s_axi_wdata;
    end
end
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking cb @(posedge mclk); endclocking
default disable iff (!resetn);
property p_fast_width; fastPileup |-> {16'h0000, runLen_reg} == maxW_reg + 32'h00000001; endproperty
a_fast_width: assert property (p_fast_width) else $error("fast pileup before width limit");
property p_fast_pulse; fastPileup |=> !fastPileup; endproperty
a_fast_pulse: assert property (p_fast_pulse) else $error("fast pileup pulse too long");
property p_slow_cause; slowPileup |-> $past(eventTrig); endproperty
a_slow_cause: assert property (p_slow_cause) else $error("slow pileup without event");
property p_slow_drop; slowPileup |-> !energyValid; endproperty
a_slow_drop: assert property (p_slow_drop) else $error("energy delivered on pileup");
property p_val_pulse; energyValid |=> !energyValid; endproperty
a_val_pulse: assert property (p_val_pulse) else $error("energy valid too long");
property p_out_hold; !energyValid |-> $stable(energyOut); endproperty
a_out_hold: assert property (p_out_hold) else $error("energy changed without valid");
property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
a_aw_pulse: assert property (p_aw_pulse) else $error("awready longer than a cycle");
property p_ar_rvalid; s_axi_arready |=> s_axi_rvalid; endproperty
a_ar_rvalid: assert property (p_ar_rvalid) else $error("read data not after arready");
property p_b_after; s_axi_awready |=> s_axi_bvalid; endproperty
a_b_after: assert property (p_b_after) else $error("write response not after awready");
c_val: cover property (energyValid);
c_slow: cover property (slowPileup);
c_fast: cover property (fastPileup);
endmodule

// File: pup_pileup_inspector_tb_top.sv
/* Testbench for the pileup inspector: bus setup, events, pileup cases.
   Assumes the inspector and its checker are compiled alongside. */
`timescale 1ns/1ns
module pup_pileup_inspector_tb_top;
reg mclk = 1'b0;
reg resetn = 1'b0;
reg fastAboveThr = 1'b0;
reg eventTrig = 1'b0;
reg [15:0] energyIn = 16'h0000;
wire [15:0] energyOut;
wire energyValid, fastPileup, slowPileup;
reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
reg [31:0] s_axi_wdata = 32'h00000000;
reg [3:0] s_axi_wstrb = 4'hf;
reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
integer miscompares = 0, testsRun = 0, nVal = 0, nSlow = 0, nFast = 0, n;
reg [31:0] rv;
reg [1:0] rr, rb;
reg [15:0] base;
pup_pileup_inspector uut (
    .mclk(mclk),
    .resetn(resetn),
    .fastAboveThr(fastAboveThr),
    .eventTrig(eventTrig),
    .energyIn(energyIn),
    .energyOut(energyOut),
    .energyValid(energyValid),
    .fastPileup(fastPileup),
    .slowPileup(slowPileup),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
);
always #25 mclk = ~mclk;
// ----------------------------------------
// Stimulus ramp and pulse counters
// ----------------------------------------
always @(posedge mclk) begin
    energyIn <= energyIn + 16'h0001;
    if (energyValid === 1'b1) nVal <= nVal + 1;
    if (slowPileup === 1'b1) nSlow <= nSlow + 1;
    if (fastPileup === 1'b1) nFast <= nFast + 1;
end
task chk(input [31:0] g, input [31:0] e);
    begin
        testsRun = testsRun + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    end
endtask
task wr(input [7:0] a, input [31:0] d);
    reg aw, w, b;
    begin
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        while (aw | w | ~b) begin
            @(posedge mclk);
            aw = aw & ~s_axi_awready;
            w = w & ~s_axi_wready;
            if (s_axi_bvalid === 1'b1) rb = s_axi_bresp;
            b = b | s_axi_bvalid;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_bready <= ~b;
        end
    end
endtask
task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    reg ar, got;
    begin
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar = 1'b1;
        got = 1'b0;
        while (ar | ~got) begin
            @(posedge mclk);
            ar = ar & ~s_axi_arready;
            if (s_axi_rvalid === 1'b1) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                got = 1'b1;
            end
            s_axi_arvalid <= ar;
            s_axi_rready <= ~got;
        end
    end
endtask
task rc(input [7:0] a, input [31:0] e);
    begin
        rd(a, rv, rr);
        chk(rv, e);
    end
endtask
task fire;
    begin
        eventTrig <= 1'b1;
        @(posedge mclk);
        eventTrig <= 1'b0;
    end
endtask
// Two events g cycles apart, then time for both to settle.
task pair(input integer g);
    begin
        @(posedge mclk);
        fire;
        repeat (g - 1) @(posedge mclk);
        fire;
        repeat (30) @(posedge mclk);
    end
endtask
task burst(input integer k);
    begin
        @(posedge mclk);
        fastAboveThr <= 1'b1;
        fire;
        repeat (k - 1) @(posedge mclk);
        fastAboveThr <= 1'b0;
        repeat (30) @(posedge mclk);
    end
endtask
task complete_run;
    begin
        $display("compares %0d miscompares %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
initial begin
    repeat (6000) @(posedge mclk);
    miscompares = miscompares + 1;
    complete_run;
end
initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rc(8'h08, 32'h8);
    rc(8'h04, 32'h2);
    rc(8'h20, 32'h13);
    rc(8'h14, 32'h3);
    $display("test 1 done");
    wr(8'h14, 32'h1);
    rc(8'h14, 32'h3);
    wr(8'h14, 32'h64);
    rc(8'h14, 32'h40);
    wr(8'h04, 32'h1);
    chk({30'h0, rb}, 32'h0);
    rc(8'h04, 32'h1);
    s_axi_wstrb <= 4'h0;
    wr(8'h04, 32'h5);
    s_axi_wstrb <= 4'hf;
    rc(8'h04, 32'h1);
    wr(8'h0c, 32'h0);
    wr(8'h40, 32'h1);
    chk({30'h0, rb}, 32'h2);
    rd(8'h40, rv, rr);
    chk({30'h0, rr}, 32'h2);
    chk(rv, 32'h0);
    $display("test 2 done");
    wr(8'h10, 32'h5);
    wr(8'h14, 32'h4);
    wr(8'h18, 32'h2);
    rc(8'h20, 32'hb);
    wr(8'h18, 32'h0);
    rc(8'h20, 32'h9);
    $display("test 3 done");
    @(posedge mclk);
    eventTrig <= 1'b1;
    base = energyIn + 16'h0009;
    @(posedge mclk);
    eventTrig <= 1'b0;
    n = 0;
    while (energyValid !== 1'b1 && n < 40) begin
        @(posedge mclk);
        n = n + 1;
    end
    chk(n, 10);
    chk({16'h0, energyOut}, {16'h0, base});
    rc(8'h30, {16'h0, base});
    rc(8'h24, 32'h1);
    $display("test 4 done");
    pair(8);
    chk(nSlow, 1);
    chk(nVal, 1);
    pair(9);
    chk(nSlow, 1);
    chk(nVal, 3);
    rc(8'h2c, 32'h1);
    $display("test 5 done");
    burst(7);
    chk(nFast, 0);
    burst(10);
    chk(nFast, 1);
    chk(nVal, 4);
    wr(8'h08, 32'h4);
    burst(3);
    chk(nVal, 5);
    burst(6);
    chk(nFast, 2);
    chk(nVal, 5);
    rc(8'h28, 32'h2);
    $display("test 6 done");
    wr(8'h00, 32'h11);
    pair(10);
    chk(nSlow, 2);
    chk(nVal, 5);
    wr(8'h00, 32'h0);
    pair(3);
    chk(nSlow, 2);
    chk(nVal, 5);
    rc(8'h2c, 32'h2);
    $display("test 7 done");
    complete_run;
end
endmodule
bind pup_pileup_inspector pup_pileup_inspector_chk #(.EW(EW)) chk (
    .mclk(mclk),
    .resetn(resetn),
    .fastAboveThr(fastAboveThr),
    .eventTrig(eventTrig),
    .energyOut(energyOut),
    .energyValid(energyValid),
    .fastPileup(fastPileup),
    .slowPileup(slowPileup),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready),
    .s_axi_arready(s_axi_arready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_rvalid(s_axi_rvalid)
);
